/* File: logic/mal_cfg.svh */
// Offsets, field positions, reset values and crossing depth for the alarm latch block.
// Assumes it is included by bare name from design files that need these constants.
`ifndef MAL_CFG_SVH
`define MAL_CFG_SVH

// Byte offsets of the interrupt enable and latch bytes
`define MAL_OFS_ALARM_EN_LO 8'hf8
`define MAL_OFS_ALARM_EN_HI 8'hf9
`define MAL_OFS_WARN_EN_LO 8'hfa
`define MAL_OFS_WARN_EN_HI 8'hfb
`define MAL_OFS_ALARM_LATCH_LO 8'hfc
`define MAL_OFS_ALARM_LATCH_HI 8'hfd
`define MAL_OFS_WARN_LATCH_LO 8'hfe
`define MAL_OFS_WARN_LATCH_HI 8'hff

// Field layout: low byte holds flags 9..2, high byte bits 7..6 hold flags 1..0
`define MAL_FLAG_COUNT 10
`define MAL_HI_FIELD_MSB 7
`define MAL_HI_FIELD_LSB 6
`define MAL_RSVD_FILL 6'h00

// Reset values
`define MAL_EN_RESET 10'h000
`define MAL_LATCH_RESET 10'h000
`define MAL_BYTE_RESET 8'h00
`define MAL_UNMAPPED_READ 8'h00

// Synchroniser depth
`define MAL_SYNC_STAGES 2

`endif

/* File: logic/mal_latch_bank.sv */
// One bank of ten interrupt enables and ten sticky latches, split over a low and a high byte.
// Assumes flags, strobes and write data all come from the system clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "mal_cfg.svh"

module mal_latch_bank (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`MAL_FLAG_COUNT-1:0] flags,
  input wire logic en_wr_lo,
  input wire logic en_wr_hi,
  input wire logic clr_wr_lo,
  input wire logic clr_wr_hi,
  input wire logic [7:0] wdata,
  output var logic [`MAL_FLAG_COUNT-1:0] enable,
  output var logic [`MAL_FLAG_COUNT-1:0] latch
);

  logic [`MAL_FLAG_COUNT-1:0] clr_vec;
  logic [`MAL_FLAG_COUNT-1:0] next_latch;

  // Reserved bits of the high byte are dropped on write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable <= `MAL_EN_RESET;
    end else begin
      if (en_wr_lo) begin
        enable[`MAL_FLAG_COUNT-1:2] <= wdata;
      end
      if (en_wr_hi) begin
        enable[1:0] <= wdata[`MAL_HI_FIELD_MSB:`MAL_HI_FIELD_LSB];
      end
    end
  end

  always_comb begin
    clr_vec = '0;
    if (clr_wr_lo) begin
      clr_vec[`MAL_FLAG_COUNT-1:2] = wdata;
    end
    if (clr_wr_hi) begin
      clr_vec[1:0] = wdata[`MAL_HI_FIELD_MSB:`MAL_HI_FIELD_LSB];
    end
    // Host data only ever clears; the set term is the flags masked by the enables
    next_latch = (latch & ~clr_vec) | (flags & enable);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= `MAL_LATCH_RESET;
    end else begin
      latch <= next_latch;
    end
  end

endmodule // mal_latch_bank

`default_nettype wire

/* File: logic/mal_pkg.sv */
// Types shared by the alarm latch block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package mal_pkg;

  typedef enum logic {
    MAL_OP_WRITE,
    MAL_OP_READ
  } mal_op_t;

  typedef enum logic {
    MAL_LS_IDLE,
    MAL_LS_WAIT
  } mal_link_state_t;

endpackage

`default_nettype wire

/* File: logic/mal_sync.sv */
// Two-flop level synchroniser, any width.
// Assumes each bit is an independent level or a toggle that changes one bit at a time.
`timescale 1ns/100ps
`default_nettype none
`include "mal_cfg.svh"

module mal_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output var logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule // mal_sync

`default_nettype wire

/* File: logic/mal_top.sv */
// Alarm and warning interrupt enables and latches driving the transmit-fault pin.
// Assumes the serial management engine presents byte accesses on LINK_CLK and that
// the monitored flags arrive as levels from logic on CLK_SYS.
`timescale 1ns/100ps
`default_nettype none
`include "mal_cfg.svh"

module mal_top
  import mal_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic LINK_CLK,
  input wire logic LINK_PTR_LOAD,
  input wire logic [7:0] LINK_ADDR,
  input wire logic LINK_WR_STB,
  input wire logic LINK_RD_STB,
  input wire logic [7:0] LINK_WDATA,
  input wire logic [`MAL_FLAG_COUNT-1:0] ALARM_FLAGS,
  input wire logic [`MAL_FLAG_COUNT-1:0] WARN_FLAGS,
  output var logic [7:0] LINK_RDATA,
  output var logic LINK_RVALID,
  output var logic LINK_BUSY,
  output var logic TX_FAULT
);

  // Link domain
  logic link_rst_q1;
  logic link_rst_n;
  logic [7:0] ptr;
  logic [7:0] req_addr;
  logic [7:0] hold_addr;
  logic [7:0] hold_data;
  mal_op_t hold_op;
  logic req_tgl;
  logic ack_seen;
  logic ack_sync;
  logic link_accept;
  mal_link_state_t link_state;
  logic ack_arrive;

  // System domain
  logic req_sync;
  logic req_seen;
  logic new_req;
  logic sys_wr;
  logic sys_rd;
  logic ack_tgl;
  logic [7:0] rdata_hold;
  logic [7:0] next_rdata;
  logic [`MAL_FLAG_COUNT-1:0] alarm_en;
  logic [`MAL_FLAG_COUNT-1:0] alarm_latch;
  logic [`MAL_FLAG_COUNT-1:0] warn_en;
  logic [`MAL_FLAG_COUNT-1:0] warn_latch;
  logic alarm_en_lo_wr;
  logic alarm_en_hi_wr;
  logic alarm_clr_lo_wr;
  logic alarm_clr_hi_wr;
  logic warn_en_lo_wr;
  logic warn_en_hi_wr;
  logic warn_clr_lo_wr;
  logic warn_clr_hi_wr;
  logic any_latch;

  // Reset released synchronously into the link domain, asserted at once
  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      link_rst_q1 <= 1'b0;
      link_rst_n <= 1'b0;
    end else begin
      link_rst_q1 <= 1'b1;
      link_rst_n <= link_rst_q1;
    end
  end

  // A strobe is taken only while no earlier access is in flight
  assign link_accept = (LINK_WR_STB || LINK_RD_STB) && (link_state == MAL_LS_IDLE);
  assign req_addr = LINK_PTR_LOAD ? LINK_ADDR : ptr;

  // Eight-bit pointer rolls from the last byte back to offset zero
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ptr <= `MAL_BYTE_RESET;
    end else if (link_accept) begin
      ptr <= req_addr + 8'h01;
    end else if (LINK_PTR_LOAD) begin
      ptr <= LINK_ADDR;
    end
  end

  // Hold registers stay still until the answer returns, so the system side may sample them
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      hold_addr <= `MAL_BYTE_RESET;
      hold_data <= `MAL_BYTE_RESET;
      hold_op <= MAL_OP_WRITE;
    end else if (link_accept) begin
      hold_addr <= req_addr;
      hold_data <= LINK_WDATA;
      hold_op <= LINK_WR_STB ? MAL_OP_WRITE : MAL_OP_READ;
    end
  end

  mal_sync #(
    .WIDTH(1)
  ) u_ack_sync (
    .clk(LINK_CLK),
    .rst_n(link_rst_n),
    .din(ack_tgl),
    .dout(ack_sync)
  );

  // The answer is honoured only while an access is waiting for it
  assign ack_arrive = (link_state == MAL_LS_WAIT) && (ack_sync != ack_seen);

  // Only one access may be in flight, since the hold registers carry it across
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      link_state <= MAL_LS_IDLE;
    end else begin
      case (link_state)
        MAL_LS_IDLE: begin
          if (link_accept) begin
            link_state <= MAL_LS_WAIT;
          end
        end
        MAL_LS_WAIT: begin
          if (ack_arrive) begin
            link_state <= MAL_LS_IDLE;
          end
        end
        default: begin
          link_state <= MAL_LS_IDLE;
        end
      endcase
    end
  end

  // One toggle per accepted access
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      req_tgl <= 1'b0;
    end else if (link_accept) begin
      req_tgl <= ~req_tgl;
    end
  end

  // Remember the answer level so only a fresh toggle ends the next access
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ack_seen <= 1'b0;
    end else if (ack_arrive) begin
      ack_seen <= ack_sync;
    end
  end

  // Busy from accept to answer; strobes meanwhile are ignored
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      LINK_BUSY <= 1'b0;
    end else if (link_accept) begin
      LINK_BUSY <= 1'b1;
    end else if (ack_arrive) begin
      LINK_BUSY <= 1'b0;
    end
  end

  // Read valid pulses for one link cycle with the answer
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      LINK_RVALID <= 1'b0;
    end else begin
      LINK_RVALID <= ack_arrive && (hold_op == MAL_OP_READ);
    end
  end

  // Read data holds until the next read answer
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      LINK_RDATA <= `MAL_BYTE_RESET;
    end else if (ack_arrive && (hold_op == MAL_OP_READ)) begin
      LINK_RDATA <= rdata_hold;
    end
  end

  // System side: one request per toggle edge
  mal_sync #(
    .WIDTH(1)
  ) u_req_sync (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .din(req_tgl),
    .dout(req_sync)
  );

  assign new_req = (req_sync != req_seen);
  assign sys_wr = new_req && (hold_op == MAL_OP_WRITE);
  assign sys_rd = new_req && (hold_op == MAL_OP_READ);

  // Byte strobes decoded once, so a bank sees at most one single-cycle pulse per access
  assign alarm_en_lo_wr = sys_wr && (hold_addr == `MAL_OFS_ALARM_EN_LO);
  assign alarm_en_hi_wr = sys_wr && (hold_addr == `MAL_OFS_ALARM_EN_HI);
  assign alarm_clr_lo_wr = sys_wr && (hold_addr == `MAL_OFS_ALARM_LATCH_LO);
  assign alarm_clr_hi_wr = sys_wr && (hold_addr == `MAL_OFS_ALARM_LATCH_HI);

  // Writes to offsets outside the area match no strobe and are dropped
  assign warn_en_lo_wr = sys_wr && (hold_addr == `MAL_OFS_WARN_EN_LO);
  assign warn_en_hi_wr = sys_wr && (hold_addr == `MAL_OFS_WARN_EN_HI);
  assign warn_clr_lo_wr = sys_wr && (hold_addr == `MAL_OFS_WARN_LATCH_LO);
  assign warn_clr_hi_wr = sys_wr && (hold_addr == `MAL_OFS_WARN_LATCH_HI);

  // Alarm bank
  mal_latch_bank u_alarm_bank (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .flags(ALARM_FLAGS),
    .en_wr_lo(alarm_en_lo_wr),
    .en_wr_hi(alarm_en_hi_wr),
    .clr_wr_lo(alarm_clr_lo_wr),
    .clr_wr_hi(alarm_clr_hi_wr),
    .wdata(hold_data),
    .enable(alarm_en),
    .latch(alarm_latch)
  );

  // Warning bank
  mal_latch_bank u_warn_bank (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .flags(WARN_FLAGS),
    .en_wr_lo(warn_en_lo_wr),
    .en_wr_hi(warn_en_hi_wr),
    .clr_wr_lo(warn_clr_lo_wr),
    .clr_wr_hi(warn_clr_hi_wr),
    .wdata(hold_data),
    .enable(warn_en),
    .latch(warn_latch)
  );

  // Reserved bits read as zero; offsets outside this area read zero
  always_comb begin
    case (hold_addr)
      `MAL_OFS_ALARM_EN_LO: next_rdata = alarm_en[`MAL_FLAG_COUNT-1:2];
      `MAL_OFS_ALARM_EN_HI: next_rdata = {alarm_en[1:0], `MAL_RSVD_FILL};
      `MAL_OFS_WARN_EN_LO: next_rdata = warn_en[`MAL_FLAG_COUNT-1:2];
      `MAL_OFS_WARN_EN_HI: next_rdata = {warn_en[1:0], `MAL_RSVD_FILL};
      `MAL_OFS_ALARM_LATCH_LO: next_rdata = alarm_latch[`MAL_FLAG_COUNT-1:2];
      `MAL_OFS_ALARM_LATCH_HI: next_rdata = {alarm_latch[1:0], `MAL_RSVD_FILL};
      `MAL_OFS_WARN_LATCH_LO: next_rdata = warn_latch[`MAL_FLAG_COUNT-1:2];
      `MAL_OFS_WARN_LATCH_HI: next_rdata = {warn_latch[1:0], `MAL_RSVD_FILL};
      default: next_rdata = `MAL_UNMAPPED_READ;
    endcase
  end

  // One answer toggle per request
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
    end else if (new_req) begin
      req_seen <= req_sync;
      ack_tgl <= ~ack_tgl;
    end
  end

  // Read data is frozen on the same edge the answer toggles, so the link side sees a stable word after the sync
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_hold <= `MAL_BYTE_RESET;
    end else if (sys_rd) begin
      rdata_hold <= next_rdata;
    end
  end

  // Enables only gate the setting of a latch; the pin looks at the latches alone
  assign any_latch = (|alarm_latch) || (|warn_latch);

  // Fault follows the latches one cycle later, straight from a flop
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      TX_FAULT <= 1'b0;
    end else begin
      TX_FAULT <= any_latch;
    end
  end

endmodule // mal_top

`default_nettype wire

/* File: tb/mal_chk.sv */
// Port checker for the alarm latch block.
// Bound onto mal_top; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
`include "mal_cfg.svh"
module mal_chk (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic LINK_CLK,
  input wire logic LINK_WR_STB,
  input wire logic LINK_RD_STB,
  input wire logic [`MAL_FLAG_COUNT-1:0] ALARM_FLAGS,
  input wire logic [`MAL_FLAG_COUNT-1:0] WARN_FLAGS,
  input wire logic [7:0] LINK_RDATA,
  input wire logic LINK_RVALID,
  input wire logic LINK_BUSY,
  input wire logic TX_FAULT
);
  logic [3:0] age;
  wire logic any_flag = |{ALARM_FLAGS, WARN_FLAGS};
  wire logic acc = (LINK_WR_STB || LINK_RD_STB) && !LINK_BUSY;
  // Cycles since the port was busy; a clear can only land near an access
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      age <= 4'hf;
    end else if (LINK_BUSY) begin
      age <= 4'h0;
    end else if (age != 4'hf) begin
      age <= age + 4'h1;
    end
  end
  a_fault_cause: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    $rose(TX_FAULT) |-> $past(any_flag, 2) || $past(any_flag, 3)) else $error("fault rose with no flag");
  a_fault_sticky: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    $fell(TX_FAULT) |-> age < 4'hc) else $error("fault fell with no host access");
  a_reset_quiet: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    $rose(RESET_N) |-> !TX_FAULT) else $error("fault high after reset");
  a_busy_accept: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
    acc |=> LINK_BUSY) else $error("access not taken");
  a_answer_bound: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
    acc |=> LINK_BUSY [*2] ##[1:6] !LINK_BUSY) else $error("answer out of window");
  a_rvalid_pulse: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
    LINK_RVALID |=> !LINK_RVALID) else $error("read valid too long");
  a_rvalid_end: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
    LINK_RVALID |-> $fell(LINK_BUSY)) else $error("read valid without answer");
  a_rdata_hold: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
    !LINK_RVALID |-> $stable(LINK_RDATA)) else $error("read data moved");
endmodule // mal_chk
bind mal_top mal_chk u_chk (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .LINK_CLK(LINK_CLK),
  .LINK_WR_STB(LINK_WR_STB), .LINK_RD_STB(LINK_RD_STB), .ALARM_FLAGS(ALARM_FLAGS),
  .WARN_FLAGS(WARN_FLAGS), .LINK_RDATA(LINK_RDATA), .LINK_RVALID(LINK_RVALID),
  .LINK_BUSY(LINK_BUSY), .TX_FAULT(TX_FAULT));
`default_nettype wire

/* File: tb/mal_host.sv */
// Host-side access model for the link port of the alarm latch block.
// Assumes a free-running link clock from the bench.
`timescale 1ns/100ps
`default_nettype none
module mal_host (
  input wire logic clk,
  input wire logic busy,
  input wire logic rvalid,
  input wire logic [7:0] rdata,
  output var logic ptr_load,
  output var logic [7:0] addr,
  output var logic wr_stb,
  output var logic rd_stb,
  output var logic [7:0] wdata
);
  initial begin
    ptr_load = 1'b0;
    addr = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wdata = 8'h00;
  end
  // One byte access; ok stays low if no answer comes in time
  task automatic xfer(input int w, input int l, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q, output logic ok);
    q = 8'h00;
    ok = 1'b0;
    @(posedge clk);
    #1;
    ptr_load = (l != 0);
    addr = a;
    wdata = d;
    wr_stb = (w != 0);
    rd_stb = (w == 0);
    @(posedge clk);
    #1;
    ptr_load = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    // Released lines must not keep showing the old byte
    addr = ~a;
    wdata = ~d;
    for (int i = 0; i < 12 && !ok; i++) begin
      @(posedge clk);
      #1;
      if (busy === 1'b0) begin
        ok = (w != 0) || (rvalid === 1'b1);
        q = rdata;
        i = 12;
      end
    end
  endtask
endmodule // mal_host
`default_nettype wire

/* File: tb/mal_top_tb_top.sv */
// Self-checking bench for the alarm latch block.
// Flags move on CLK_SYS; bytes go through the host model on the link clock.
`timescale 1ns/100ps
`default_nettype none
module mal_top_tb_top;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] fl [2];
  logic ld, ws, rs, busy, rv, fault;
  logic [7:0] a, wd, rdat;
  int failures = 0;
  int cmp_count = 0;
  always #2 clk = ~clk;
  // Offset keeps link edges apart from system edges
  initial begin
    #1.3;
    forever #6 lclk = ~lclk;
  end
  mal_top u_dut (.CLK_SYS(clk), .RESET_N(rst_n), .LINK_CLK(lclk), .LINK_PTR_LOAD(ld), .LINK_ADDR(a),
    .LINK_WR_STB(ws), .LINK_RD_STB(rs), .LINK_WDATA(wd), .ALARM_FLAGS(fl[0]), .WARN_FLAGS(fl[1]),
    .LINK_RDATA(rdat), .LINK_RVALID(rv), .LINK_BUSY(busy), .TX_FAULT(fault));
  mal_host u_host (.clk(lclk), .busy(busy), .rvalid(rv), .rdata(rdat), .ptr_load(ld), .addr(a),
    .wr_stb(ws), .rd_stb(rs), .wdata(wd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic xf(input int w, input int l, input logic [7:0] ad, input logic [7:0] d, input logic [7:0] exp);
    logic [7:0] q;
    logic ok;
    u_host.xfer(w, l, ad, d, q, ok);
    chk({7'h0, ok}, 8'h01);
    if (!ok) begin
      end_of_test();
    end
    if (w == 0) begin
      chk(q, exp);
    end
  endtask
  task automatic setf(input int b, input logic [9:0] v);
    @(posedge clk);
    #1;
    fl[b] = v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  initial begin
    fl[0] = 10'h000;
    fl[1] = 10'h000;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge lclk);
    xf(1, 1, 8'hf8, 8'h81, 8'h00);
    xf(0, 1, 8'hf8, 8'h00, 8'h81);
    for (int i = 1; i < 256; i++) begin
      xf(0, 0, 8'h00, 8'h00, 8'h00);
    end
    xf(0, 0, 8'h00, 8'h00, 8'h81);
    $display("test 1 done");
    xf(1, 1, 8'hf9, 8'hff, 8'h00);
    xf(1, 0, 8'h00, 8'ha5, 8'h00);
    xf(1, 0, 8'h00, 8'h5a, 8'h00);
    xf(0, 1, 8'hf8, 8'h00, 8'h81);
    xf(0, 0, 8'h00, 8'h00, 8'hc0);
    xf(0, 0, 8'h00, 8'h00, 8'ha5);
    xf(0, 0, 8'h00, 8'h00, 8'h40);
    xf(1, 1, 8'hfc, 8'hff, 8'h00);
    xf(0, 1, 8'hfc, 8'h00, 8'h00);
    xf(1, 1, 8'h10, 8'hff, 8'h00);
    xf(0, 1, 8'h10, 8'h00, 8'h00);
    chk({7'h0, fault}, 8'h00);
    $display("test 2 done");
    for (int i = 0; i < 4; i++) begin
      xf(1, 1, 8'(248 + i), 8'hff, 8'h00);
    end
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 10; i++) begin
        setf(b, 10'h001 << i);
        setf(b, 10'h000);
        xf(0, 1, 8'(252 + 2 * b), 8'h00, i > 1 ? 8'h01 << (i - 2) : 8'h00);
        xf(0, 0, 8'h00, 8'h00, i < 2 ? 8'h40 << i : 8'h00);
        chk({7'h0, fault}, 8'h01);
        xf(1, 1, 8'(252 + 2 * b), 8'hff, 8'h00);
        xf(1, 0, 8'h00, 8'hff, 8'h00);
        setf(b, 10'h000);
        chk({7'h0, fault}, 8'h00);
      end
    end
    $display("test 3 done");
    setf(0, 10'h300);
    setf(0, 10'h000);
    xf(1, 1, 8'hfc, 8'h40, 8'h00);
    xf(0, 1, 8'hfc, 8'h00, 8'h80);
    setf(0, 10'h200);
    xf(1, 1, 8'hfc, 8'hff, 8'h00);
    xf(0, 1, 8'hfc, 8'h00, 8'h80);
    chk({7'h0, fault}, 8'h01);
    xf(1, 1, 8'hf8, 8'h00, 8'h00);
    xf(1, 1, 8'hfc, 8'hff, 8'h00);
    xf(0, 1, 8'hfc, 8'h00, 8'h00);
    setf(0, 10'h000);
    chk({7'h0, fault}, 8'h00);
    $display("test 4 done");
    setf(1, 10'h001);
    chk({7'h0, fault}, 8'h01);
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    setf(1, 10'h000);
    repeat (3) @(posedge lclk);
    chk({7'h0, fault}, 8'h00);
    xf(0, 1, 8'hfb, 8'h00, 8'h00);
    xf(0, 1, 8'hff, 8'h00, 8'h00);
    $display("test 5 done");
    end_of_test();
  end
endmodule // mal_top_tb_top
`default_nettype wire
